//--- src/decoder_pkg.sv
// Shared constants, types and carriers for the 14-bit instruction decoder.
// Assumes a single core clock and a classic Wishbone register port.
package decoder_pkg;

	// ----------------------------------------------------------------
	// Instruction word fields
	// ----------------------------------------------------------------
	localparam int unsigned IW         = 14;
	localparam logic [1:0]  GRP_BYTE   = 2'h0;
	localparam logic [1:0]  GRP_BIT    = 2'h1;
	localparam logic [1:0]  GRP_CTRL   = 2'h2;
	localparam logic [1:0]  GRP_LIT    = 2'h3;

	// Byte group opcodes, bits 11:8.
	localparam logic [3:0]  OP_STORE   = 4'h0;
	localparam logic [3:0]  OP_CLEAR   = 4'h1;
	localparam logic [3:0]  OP_SUB     = 4'h2;
	localparam logic [3:0]  OP_DEC     = 4'h3;
	localparam logic [3:0]  OP_OR      = 4'h4;
	localparam logic [3:0]  OP_AND     = 4'h5;
	localparam logic [3:0]  OP_XOR     = 4'h6;
	localparam logic [3:0]  OP_ADD     = 4'h7;
	localparam logic [3:0]  OP_MOVE    = 4'h8;
	localparam logic [3:0]  OP_COMP    = 4'h9;
	localparam logic [3:0]  OP_INC     = 4'hA;
	localparam logic [3:0]  OP_DECSKIP = 4'hB;
	localparam logic [3:0]  OP_RRC     = 4'hC;
	localparam logic [3:0]  OP_RLC     = 4'hD;
	localparam logic [3:0]  OP_SWAP    = 4'hE;
	localparam logic [3:0]  OP_INCSKIP = 4'hF;

	// Bit group opcodes, bits 11:10.
	localparam logic [1:0]  BOP_CLR    = 2'h0;
	localparam logic [1:0]  BOP_SET    = 2'h1;
	localparam logic [1:0]  BOP_TSTCLR = 2'h2;
	localparam logic [1:0]  BOP_TSTSET = 2'h3;

	// Literal group opcodes, bits 11:8 with don't-care bits stripped.
	localparam logic [1:0]  LOP_MOVE   = 2'h0;
	localparam logic [1:0]  LOP_RETURN = 2'h1;
	localparam logic [2:0]  LOP_SUB    = 3'h6;
	localparam logic [2:0]  LOP_ADD    = 3'h7;
	localparam logic [3:0]  LOP_OR     = 4'h8;
	localparam logic [3:0]  LOP_AND    = 4'h9;
	localparam logic [3:0]  LOP_XOR    = 4'hA;

	// Fixed codes in the low seven bits under opcode 0000 with bit 7 clear.
	localparam logic [6:0]  FIX_SLEEP  = 7'h63;
	localparam logic [6:0]  FIX_WDT    = 7'h64;
	localparam logic [6:0]  FIX_RET    = 7'h08;
	localparam logic [6:0]  FIX_RETI   = 7'h09;
	localparam logic [4:0]  FIX_IDLE   = 5'h00;

	// ----------------------------------------------------------------
	// File addresses with side effects
	// ----------------------------------------------------------------
	localparam logic [6:0]  TIMER_ADDR = 7'h01;
	localparam logic [6:0]  PORT_ADDR  = 7'h06;

	// ----------------------------------------------------------------
	// Register map and reset values
	// ----------------------------------------------------------------
	localparam logic [3:0]  REG_CTRL   = 4'h0;
	localparam logic [3:0]  REG_STATUS = 4'h4;
	localparam logic [3:0]  REG_ACC    = 4'h8;
	localparam logic [3:0]  REG_INSTR  = 4'hC;
	localparam logic        RUN_RESET  = 1'b1;
	localparam int unsigned RUN_BIT    = 0;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	// Gray-coded oscillator phases; four of them make one instruction cycle.
	typedef enum logic [1:0] {
		PH_Q1 = 2'b00,
		PH_Q2 = 2'b01,
		PH_Q3 = 2'b11,
		PH_Q4 = 2'b10
	} phase_t;

	typedef enum logic [3:0] {
		ALU_PASS_A, ALU_PASS_B, ALU_ZERO, ALU_ADD, ALU_SUB, ALU_AND, ALU_OR,
		ALU_XOR, ALU_COM, ALU_INC, ALU_DEC, ALU_RLC, ALU_RRC, ALU_SWAP,
		ALU_BCLR, ALU_BSET
	} alu_op_t;

	typedef struct packed {
		logic [7:0] result;
		logic       carry;
		logic       dcarry;
		logic       zero;
	} alu_out_t;

	typedef struct packed {
		logic       cyc;
		logic       stb;
		logic       we;
		logic [3:0] adr;
		logic [3:0] sel;
		logic [31:0] dat;
	} wb_req_t;

	typedef struct packed {
		logic        ack;
		logic [31:0] dat;
	} wb_rsp_t;

	typedef struct packed {
		logic        pc_load;
		logic [10:0] pc_target;
		logic        stack_push;
		logic        stack_pop;
		logic        watchdog_clear;
		logic        prescaler_clear;
		logic        second_cycle;
	} core_ctl_t;

	typedef struct packed {
		phase_t            ph;
		logic [IW-1:0]     ir;
		logic              flush;
		logic              run;
		logic              sleeping;
		logic              carry;
		logic              digit_carry_flag;
		logic              zero;
		logic              timeout_status;
		logic              powerdown_status;
		logic [7:0]        acc;
		logic [127:0][7:0] file;
		core_ctl_t         ctl;
		wb_rsp_t           rsp;
	} core_state_t;

endpackage

//--- src/alu_unit.sv
// Eight-bit arithmetic and logic unit of the decoder core.
// Purely combinational; the caller registers whatever it keeps.
`timescale 1ns/1ps
module alu_unit (
	// Operation and operands
	input  decoder_pkg::alu_op_t  op,
	input  wire logic [7:0]       acc,
	input  wire logic [7:0]       operand,
	input  wire logic             carry_in,
	input  wire logic [2:0]       bit_sel,
	// Result and flags
	output decoder_pkg::alu_out_t res
);
	import decoder_pkg::*;

	logic [8:0] sum;
	logic [4:0] nib;
	logic [7:0] mask;

	always_comb begin
		sum        = 9'h000;
		nib        = 5'h00;
		mask       = 8'h01 << bit_sel;
		res.result = operand;
		res.carry  = carry_in;
		res.dcarry = 1'b0;
		case (op)
			ALU_PASS_A: res.result = acc;
			ALU_PASS_B: res.result = operand;
			ALU_ZERO:   res.result = 8'h00;
			ALU_ADD: begin
				sum        = {1'b0, acc} + {1'b0, operand};
				nib        = {1'b0, acc[3:0]} + {1'b0, operand[3:0]};
				res.result = sum[7:0];
				res.carry  = sum[8];
				res.dcarry = nib[4];
			end
			// Carry set means no borrow, as the two's complement add gives it.
			ALU_SUB: begin
				sum        = {1'b0, operand} + {1'b0, ~acc} + 9'h001;
				nib        = {1'b0, operand[3:0]} + {1'b0, ~acc[3:0]} + 5'h01;
				res.result = sum[7:0];
				res.carry  = sum[8];
				res.dcarry = nib[4];
			end
			ALU_AND:  res.result = acc & operand;
			ALU_OR:   res.result = acc | operand;
			ALU_XOR:  res.result = acc ^ operand;
			ALU_COM:  res.result = ~operand;
			ALU_INC:  res.result = operand + 8'h01;
			ALU_DEC:  res.result = operand - 8'h01;
			ALU_RLC: begin
				res.result = {operand[6:0], carry_in};
				res.carry  = operand[7];
			end
			ALU_RRC: begin
				res.result = {carry_in, operand[7:1]};
				res.carry  = operand[0];
			end
			ALU_SWAP: res.result = {operand[3:0], operand[7:4]};
			ALU_BCLR: res.result = operand & ~mask;
			ALU_BSET: res.result = operand | mask;
			default:  res.result = operand;
		endcase
		res.zero = (res.result == 8'h00);
	end

endmodule // alu_unit

//--- src/instr_decoder.sv
// Decode and execute unit for 14-bit instruction words, with Wishbone status port.
// Assumes program memory presents the fetched word during phase Q1 of each cycle.
`timescale 1ns/1ps
module instr_decoder (
	// Clock and reset
	input  wire logic              sys_clk,
	input  wire logic              reset_n,
	// Program memory
	input  wire logic [13:0]       instr_word,
	// Pins and timer
	input  wire logic [7:0]        port_pins,
	input  wire logic              prescaler_on_timer,
	input  wire logic              wake_event,
	// Core control outputs
	output decoder_pkg::core_ctl_t ctl,
	output logic [7:0]             port_out,
	output logic                   sleep_mode,
	output logic                   timeout_status,
	output logic                   powerdown_status,
	// Wishbone slave
	input  decoder_pkg::wb_req_t   wb_req,
	output decoder_pkg::wb_rsp_t   wb_rsp
);
	import decoder_pkg::*;

	core_state_t s_r;
	core_state_t s_nxt;

	// ----------------------------------------------------------------
	// Decode of the held instruction word
	// ----------------------------------------------------------------
	logic [1:0]  grp;
	logic [3:0]  opc;
	logic        dbit;
	logic [6:0]  fadr;
	logic [2:0]  bsel;
	logic [7:0]  lit;
	logic [7:0]  operand;
	alu_op_t     aop;
	alu_out_t    alu;
	logic        wr_acc, wr_file, upd_c, upd_digit, upd_z;
	logic        skip_zero, skip_clr, skip_set, branch, push, pop;
	logic        is_sleep, is_wdt, commit, skip_take, two_cycle, bus_take;

	assign grp  = s_r.ir[13:12];
	assign opc  = s_r.ir[11:8];
	assign dbit = s_r.ir[7];
	assign fadr = s_r.ir[6:0];
	assign bsel = s_r.ir[9:7];
	assign lit  = s_r.ir[7:0];
	// Read-modify-write of the port sees the pins, not the latch.
	assign operand = (fadr == PORT_ADDR) ? port_pins : s_r.file[fadr];

	always_comb begin
		aop = ALU_PASS_B;
		{wr_acc, wr_file, upd_c, upd_digit, upd_z} = 5'h00;
		{skip_zero, skip_clr, skip_set, branch, push, pop} = 6'h00;
		{is_sleep, is_wdt} = 2'h0;
		case (grp)
			GRP_BYTE: begin
				wr_acc  = !dbit;
				wr_file = dbit;
				upd_z   = 1'b1;
				case (opc)
					OP_STORE: begin
						aop     = ALU_PASS_A;
						upd_z   = 1'b0;
						wr_acc  = 1'b0;
						wr_file = dbit;
						if (!dbit) begin
							wr_file  = 1'b0;
							is_sleep = (fadr == FIX_SLEEP);
							is_wdt   = (fadr == FIX_WDT);
							pop      = (fadr == FIX_RET) || (fadr == FIX_RETI);
							branch   = pop;
						end
					end
					OP_CLEAR: aop = ALU_ZERO;
					OP_SUB: begin
						aop = ALU_SUB;
						{upd_c, upd_digit} = 2'h3;
					end
					OP_DEC:  aop = ALU_DEC;
					OP_OR:   aop = ALU_OR;
					OP_AND:  aop = ALU_AND;
					OP_XOR:  aop = ALU_XOR;
					OP_ADD: begin
						aop = ALU_ADD;
						{upd_c, upd_digit} = 2'h3;
					end
					OP_MOVE: aop = ALU_PASS_B;
					OP_COMP: aop = ALU_COM;
					OP_INC:  aop = ALU_INC;
					OP_DECSKIP: begin
						aop       = ALU_DEC;
						upd_z     = 1'b0;
						skip_zero = 1'b1;
					end
					OP_RRC: begin
						aop   = ALU_RRC;
						upd_z = 1'b0;
						upd_c = 1'b1;
					end
					OP_RLC: begin
						aop   = ALU_RLC;
						upd_z = 1'b0;
						upd_c = 1'b1;
					end
					OP_SWAP: begin
						aop   = ALU_SWAP;
						upd_z = 1'b0;
					end
					default: begin
						aop       = ALU_INC;
						upd_z     = 1'b0;
						skip_zero = 1'b1;
					end
				endcase
			end
			GRP_BIT: begin
				case (opc[3:2])
					BOP_CLR: begin
						aop     = ALU_BCLR;
						wr_file = 1'b1;
					end
					BOP_SET: begin
						aop     = ALU_BSET;
						wr_file = 1'b1;
					end
					BOP_TSTCLR: skip_clr = 1'b1;
					default:    skip_set = 1'b1;
				endcase
			end
			GRP_CTRL: begin
				branch = 1'b1;
				push   = !opc[3];
			end
			default: begin
				wr_acc = 1'b1;
				upd_z  = 1'b1;
				if (opc[3:2] == LOP_MOVE) begin
					upd_z = 1'b0;
				end else if (opc[3:2] == LOP_RETURN) begin
					upd_z  = 1'b0;
					pop    = 1'b1;
					branch = 1'b1;
				end else if (opc[3:1] == LOP_ADD) begin
					aop = ALU_ADD;
					{upd_c, upd_digit} = 2'h3;
				end else if (opc[3:1] == LOP_SUB) begin
					aop = ALU_SUB;
					{upd_c, upd_digit} = 2'h3;
				end else if (opc == LOP_OR) begin
					aop = ALU_OR;
				end else if (opc == LOP_AND) begin
					aop = ALU_AND;
				end else if (opc == LOP_XOR) begin
					aop = ALU_XOR;
				end
			end
		endcase
	end

	alu_unit u_alu (
		.op       (aop),
		.acc      (s_r.acc),
		.operand  ((grp == GRP_LIT) ? lit : operand),
		.carry_in (s_r.carry),
		.bit_sel  (bsel),
		.res      (alu)
	);

	// ----------------------------------------------------------------
	// Sequencing, execution and register port
	// ----------------------------------------------------------------
	assign commit    = (s_r.ph == PH_Q4) && s_r.run && !s_r.sleeping && !s_r.flush;
	assign skip_take = (skip_zero && alu.zero) || (skip_clr && !operand[bsel])
		|| (skip_set && operand[bsel]);
	assign two_cycle = branch || skip_take;
	assign bus_take  = wb_req.cyc && wb_req.stb && !s_r.rsp.ack;

	always_comb begin
		s_nxt     = s_r;
		s_nxt.ctl = '0;
		// The phase counter runs even while asleep so wake-up lands on a clean Q1.
		case (s_r.ph)
			PH_Q1:   s_nxt.ph = PH_Q2;
			PH_Q2:   s_nxt.ph = PH_Q3;
			PH_Q3:   s_nxt.ph = PH_Q4;
			default: s_nxt.ph = PH_Q1;
		endcase
		if (s_r.ph == PH_Q1) begin
			s_nxt.ir = instr_word;
		end
		// The cycle after a branch or true test only retires the flush.
		if (s_r.ph == PH_Q4 && s_r.flush) begin
			s_nxt.flush            = 1'b0;
			s_nxt.ctl.second_cycle = 1'b1;
		end
		if (commit) begin
			if (wr_acc) begin
				s_nxt.acc = (grp == GRP_LIT && opc[3:2] <= LOP_RETURN) ? lit : alu.result;
			end
			if (wr_file) begin
				s_nxt.file[fadr] = alu.result;
				s_nxt.ctl.prescaler_clear = (fadr == TIMER_ADDR) && prescaler_on_timer;
			end
			if (upd_c) begin
				s_nxt.carry = alu.carry;
			end
			if (upd_digit) begin
				s_nxt.digit_carry_flag = alu.dcarry;
			end
			if (upd_z) begin
				s_nxt.zero = alu.zero;
			end
			s_nxt.flush          = two_cycle;
			s_nxt.ctl.pc_load    = (grp == GRP_CTRL);
			s_nxt.ctl.pc_target  = s_r.ir[10:0];
			s_nxt.ctl.stack_push = push;
			s_nxt.ctl.stack_pop  = pop;
			if (is_sleep) begin
				s_nxt.sleeping         = 1'b1;
				s_nxt.timeout_status   = 1'b1;
				s_nxt.powerdown_status = 1'b0;
			end
			if (is_wdt) begin
				s_nxt.ctl.watchdog_clear = 1'b1;
				s_nxt.timeout_status     = 1'b1;
				s_nxt.powerdown_status   = 1'b1;
			end
		end
		if (wake_event) begin
			s_nxt.sleeping = 1'b0;
		end
		s_nxt.rsp.ack = bus_take;
		s_nxt.rsp.dat = 32'h0000_0000;
		if (wb_req.cyc && wb_req.stb && s_r.rsp.ack && wb_req.we
			&& wb_req.adr == REG_CTRL && wb_req.sel[0]) begin
			s_nxt.run = wb_req.dat[RUN_BIT];
		end
		if (bus_take && !wb_req.we) begin
			if (wb_req.adr == REG_CTRL) begin
				s_nxt.rsp.dat[RUN_BIT] = s_r.run;
			end else if (wb_req.adr == REG_STATUS) begin
				s_nxt.rsp.dat[5:0] = {s_r.sleeping, s_r.powerdown_status, s_r.timeout_status,
					s_r.zero, s_r.digit_carry_flag, s_r.carry};
			end else if (wb_req.adr == REG_ACC) begin
				s_nxt.rsp.dat[7:0] = s_r.acc;
			end else if (wb_req.adr == REG_INSTR) begin
				s_nxt.rsp.dat[13:0] = s_r.ir;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_r                  <= '0;
			s_r.ph               <= PH_Q1;
			s_r.run              <= RUN_RESET;
			s_r.timeout_status   <= 1'b1;
			s_r.powerdown_status <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	assign ctl              = s_r.ctl;
	assign port_out         = s_r.file[PORT_ADDR];
	assign sleep_mode       = s_r.sleeping;
	assign timeout_status   = s_r.timeout_status;
	assign powerdown_status = s_r.powerdown_status;
	assign wb_rsp           = s_r.rsp;

	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	property p_phase_period;
		(s_r.ph == PH_Q4) |-> ##4 (s_r.ph == PH_Q4);
	endproperty
	a_phase_period: assert property (p_phase_period) else $error("phase period not four");

	property p_dest_acc;
		(commit && grp == GRP_BYTE && wr_acc) |=> (s_r.acc == $past(alu.result));
	endproperty
	a_dest_acc: assert property (p_dest_acc) else $error("byte result not in accumulator");

	property p_add_lit;
		(commit && grp == GRP_LIT && opc[3:1] == LOP_ADD)
			|=> (s_r.acc == $past(s_r.acc) + $past(lit));
	endproperty
	a_add_lit: assert property (p_add_lit) else $error("add literal sum wrong");

	property p_sub_lit;
		(commit && grp == GRP_LIT && opc[3:1] == LOP_SUB)
			|=> (s_r.acc == $past(lit) - $past(s_r.acc)) && (s_r.carry == ($past(lit) >= $past(s_r.acc)));
	endproperty
	a_sub_lit: assert property (p_sub_lit) else $error("literal minus accumulator wrong");

	property p_return_load_literal;
		(commit && grp == GRP_LIT && opc[3:2] == LOP_RETURN)
			|=> ctl.stack_pop && (s_r.acc == $past(lit)) ##4 ctl.second_cycle;
	endproperty
	a_return_load_literal: assert property (p_return_load_literal) else $error("return with literal wrong");

	property p_two_cycle;
		(commit && two_cycle) |=> s_r.flush ##1 (s_r.flush && $stable(s_r.acc)) [*3];
	endproperty
	a_two_cycle: assert property (p_two_cycle) else $error("second cycle not idle");

	property p_skip_dec;
		(commit && grp == GRP_BYTE && opc == OP_DECSKIP)
			|=> (s_r.flush == ($past(operand) == 8'h01)) && $stable(s_r.zero);
	endproperty
	a_skip_dec: assert property (p_skip_dec) else $error("decrement skip wrong");

	property p_sleep;
		(commit && is_sleep && !wake_event) |=> sleep_mode && timeout_status && !powerdown_status;
	endproperty
	a_sleep: assert property (p_sleep) else $error("standby flags wrong");

	property p_prescaler;
		(commit && wr_file && fadr == TIMER_ADDR && prescaler_on_timer) |=> ctl.prescaler_clear;
	endproperty
	a_prescaler: assert property (p_prescaler) else $error("prescaler not cleared");

	property p_wb_ack;
		(wb_req.cyc && wb_req.stb && !wb_rsp.ack) |=> wb_rsp.ack ##1 !wb_rsp.ack;
	endproperty
	a_wb_ack: assert property (p_wb_ack) else $error("bus ack timing wrong");

endmodule // instr_decoder

//--- tb/prog_mem.sv
// Program memory stand-in: presents the word chosen by the bench in each fetch slot.
// Assumes the decoder samples its instruction bus in the first of four phases.
`timescale 1ns/1ps
module prog_mem (
	// Clock and reset
	input  wire logic        sys_clk,
	input  wire logic        reset_n,
	// Word chosen by the bench
	input  wire logic [13:0] word_sel,
	// Fetch bus
	output logic [13:0]      instr_word,
	output logic             fetch_q1
);
	logic [1:0] phase_r;

	always_ff @(posedge sys_clk or negedge reset_n) begin
		if (!reset_n) begin
			phase_r <= 2'h0;
		end else begin
			phase_r <= phase_r + 2'h1;
		end
	end

	// Outside the fetch phase the bus shows the inverse, so a late sample is caught.
	assign fetch_q1   = (phase_r == 2'h0);
	assign instr_word = fetch_q1 ? word_sel : ~word_sel;
endmodule // prog_mem

//--- tb/tb_instr_decoder.sv
// Self-checking bench for the instruction decoder.
// Assumes the program memory model and the Wishbone status port.
`timescale 1ns/1ps
module tb_instr_decoder;
	import decoder_pkg::*;
	logic        sys_clk, reset_n, prescaler_on_timer, wake_event, fetch_q1;
	logic [13:0] word_sel, instr_word, w;
	logic [7:0]  port_pins, port_out;
	logic        sleep_mode, timeout_status, powerdown_status;
	core_ctl_t   ctl, c1, c2;
	wb_req_t     wb_req;
	wb_rsp_t     wb_rsp;
	logic [31:0] rd, lfsr;
	logic [10:0] m;
	logic [3:0]  ops [9] = '{4'h0, 4'h3, 4'h8, 4'h9, 4'hA, 4'hC, 4'hD, 4'hE, 4'hF};
	logic [13:0] corner [5] = '{14'h3010, 14'h3EF0, 14'h3C00, 14'h3F0F, 14'h3C01};
	int          n_errors, check_count;

	prog_mem prog_mem_i (.sys_clk(sys_clk), .reset_n(reset_n), .word_sel(word_sel),
		.instr_word(instr_word), .fetch_q1(fetch_q1));
	instr_decoder instr_decoder_i (.sys_clk(sys_clk), .reset_n(reset_n),
		.instr_word(instr_word), .port_pins(port_pins),
		.prescaler_on_timer(prescaler_on_timer), .wake_event(wake_event), .ctl(ctl),
		.port_out(port_out), .sleep_mode(sleep_mode), .timeout_status(timeout_status),
		.powerdown_status(powerdown_status), .wb_req(wb_req), .wb_rsp(wb_rsp));

	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	function automatic logic [31:0] lfsr_next(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction

	// Expected {acc, carry, digit carry, zero} after a literal operation on state s.
	function automatic logic [10:0] lit_exp(input logic [13:0] i, input logic [10:0] s);
		logic [7:0] a;
		logic [7:0] k;
		logic [8:0] t;
		a = s[10:3];
		k = i[7:0];
		casez (i[11:8])
			4'b00??: return {k, s[2:0]};
			4'b1000: t = {1'b0, a | k};
			4'b1001: t = {1'b0, a & k};
			4'b1010: t = {1'b0, a ^ k};
			4'b110?: begin
				t = {1'b0, k} - {1'b0, a};
				return {t[7:0], ~t[8], k[3:0] >= a[3:0], t[7:0] == 8'h00};
			end
			default: begin
				t = {1'b0, k} + {1'b0, a};
				return {t[7:0], t[8], ({1'b0, k[3:0]} + {1'b0, a[3:0]}) > 5'h0F,
					t[7:0] == 8'h00};
			end
		endcase
		return {t[7:0], s[2:1], t[7:0] == 8'h00};
	endfunction

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			n_errors++;
			$display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic wb(input logic we, input logic [3:0] adr, input logic [31:0] dat);
		int t;
		t = 0;
		@(posedge sys_clk);
		wb_req <= '{cyc: 1'b1, stb: 1'b1, we: we, adr: adr, sel: 4'hF, dat: dat};
		do begin
			@(posedge sys_clk);
			t++;
		end while (wb_rsp.ack !== 1'b1 && t < 50);
		if (wb_rsp.ack !== 1'b1) n_errors++;
		rd = wb_rsp.dat;
		wb_req <= '0;
	endtask

	// Issue one word; c1 holds the control pulses of its cycle, c2 those of the next.
	task automatic exec(input logic [13:0] i);
		word_sel <= i;
		do @(posedge sys_clk); while (fetch_q1 !== 1'b1);
		word_sel <= 14'h0000;
		repeat (4) @(posedge sys_clk);
		c1 = ctl;
		repeat (4) @(posedge sys_clk);
		c2 = ctl;
	endtask

	task automatic expect_core(input logic [10:0] e);
		m = e;
		wb(1'b0, REG_ACC, 32'h0000_0000);
		check(rd, {24'h0, m[10:3]});
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		check(rd[2:0], {m[0], m[1], m[2]});
	endtask

	task automatic lit(input logic [13:0] i);
		exec(i);
		expect_core(lit_exp(i, m));
	endtask

	task automatic results;
		if (n_errors == 0 && check_count > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask

	// ----------------------------------------------------------------
	// Stimulus
	// ----------------------------------------------------------------
	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	initial begin
		repeat (8000) @(posedge sys_clk);
		n_errors++;
		results();
	end

	initial begin
		reset_n = 1'b0;
		word_sel = 14'h0000;
		port_pins = 8'h00;
		prescaler_on_timer = 1'b0;
		wake_event = 1'b0;
		wb_req = '0;
		lfsr = 32'hac67;
		m = 11'h000;
		repeat (3) @(posedge sys_clk);
		reset_n <= 1'b1;
		wb(1'b0, REG_STATUS, 32'h0000_0000);
		check(rd, 32'h0000_0018);
		wb(1'b0, REG_CTRL, 32'h0000_0000);
		check(rd, 32'h0000_0001);
		wb(1'b0, 4'h2, 32'h0000_0000);
		check(rd, 32'h0000_0000);
		foreach (corner[j]) lit(corner[j]);
		for (int i = 0; i < 24; i++) begin
			lfsr = lfsr_next(lfsr);
			w = {2'b11, ops[lfsr[3:0] % 9], lfsr[15:8]};
			lit(w);
		end
		// Sum of 0x88 and itself lands in the file register, then is moved back.
		exec(14'h3088);
		exec(14'h00A0);
		exec(14'h07A0);
		exec(14'h0820);
		expect_core({8'h10, 3'b110});
		lfsr = lfsr_next(lfsr);
		port_pins <= lfsr[7:0];
		exec(14'h0806);
		expect_core({lfsr[7:0], m[2:1], lfsr[7:0] == 8'h00});
		exec(14'h0086);
		check(port_out, lfsr[7:0]);
		prescaler_on_timer <= 1'b1;
		exec(14'h0081);
		check(c1.prescaler_clear, 1'b1);
		exec(14'h30FF);
		exec(14'h00A1);
		exec(14'h0FA1);
		check(c2.second_cycle, 1'b1);
		exec(14'h0821);
		expect_core({8'h00, m[2:1], 1'b1});
		exec(14'h0D20);
		expect_core({8'h21, 3'b011});
		exec(14'h0C20);
		expect_core({8'h08, 3'b011});
		exec(14'h0420);
		expect_core({8'h18, 3'b010});
		exec(14'h0620);
		expect_core({8'h08, 3'b010});
		exec(14'h17A0);
		exec(14'h0820);
		expect_core({8'h90, 3'b010});
		exec(14'h0220);
		expect_core({8'h00, 3'b111});
		exec(14'h0E20);
		expect_core({8'h09, 3'b111});
		exec(14'h0920);
		expect_core({8'h6F, 3'b110});
		exec(14'h0520);
		expect_core({8'h00, 3'b111});
		exec(14'h0A20);
		expect_core({8'h91, 3'b110});
		exec(14'h0320);
		expect_core({8'h8F, 3'b110});
		exec(14'h13A0);
		exec(14'h0820);
		expect_core({8'h10, 3'b110});
		exec(14'h0103);
		expect_core({8'h00, 3'b111});
		exec(14'h3001);
		exec(14'h00A2);
		exec(14'h0BA2);
		check(c2.second_cycle, 1'b1);
		exec(14'h1821);
		check(c2.second_cycle, 1'b1);
		exec(14'h1C21);
		check(c2.second_cycle, 1'b0);
		exec(14'h2DA5);
		check({c1.pc_load, c1.pc_target, c2.second_cycle}, {1'b1, 11'h5A5, 1'b1});
		exec(14'h2123);
		check({c1.stack_push, c1.pc_target}, {1'b1, 11'h123});
		exec(14'h3455);
		check(c1.stack_pop, 1'b1);
		expect_core({8'h55, m[2:0]});
		exec(14'h0008);
		check(c1.stack_pop, 1'b1);
		exec(14'h0009);
		check(c1.stack_pop, 1'b1);
		wb(1'b1, REG_CTRL, 32'h0000_0000);
		exec(14'h3E01);
		expect_core(m);
		wb(1'b1, REG_CTRL, 32'h0000_0001);
		exec(14'h0063);
		check({sleep_mode, timeout_status, powerdown_status}, 3'b110);
		@(posedge sys_clk);
		wake_event <= 1'b1;
		@(posedge sys_clk);
		wake_event <= 1'b0;
		exec(14'h0064);
		check({c1.watchdog_clear, timeout_status, powerdown_status}, 3'b111);
		results();
	end
endmodule // tb_instr_decoder
